// [hw/vaddr_reloc.sv]
// Virtual-to-physical address relocation unit with page protection.
// Assumes one 100 MHz clock shared with the processor; all inputs except nrst_in are
// synchronous. Bus handshakes are abstracted to one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module vaddr_reloc
   import vaddr_reloc_pkg::*;
(
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire bus_req_t    req_in,
   input  wire impl_t       impl_in,
   input  wire logic [15:0] internal_write_data_mux_in,
   input  wire logic [15:0] ir_in,
   input  wire logic [8:0]  microbranch_pointer_in,
   input  wire logic        console_in,
   input  wire logic [17:0] switch_in,
   output logic [17:0]      pba_out,
   output logic [1:0]       target_out,
   output logic [15:0]      bus_data_out,
   output logic             bus_data_oe_out,
   output logic [15:0]      rd_bus_out,
   output logic             rd_bus_oe_out,
   output logic             msyn_inhibit_out,
   output logic             ssyn_out,
   output logic             fault_out,
   output logic             fetch_repeat_out
);

   logic              rst_meta_r;
   logic              rst_n_r;
   logic [11:0]       par_r [8];
   logic [15:0]       pdr_r [8];
   logic [15:0]       sr0_r;
   logic [15:0]       sr2_r;
   logic [3:0]        ctl_r;
   logic [3:0]        psx_r;
   logic [1:0]        tmp_r;
   logic              mtp_r;
   logic              mfp_r;
   logic [17:0]       pba_nxt;
   logic [2:0]        pg;
   logic [1:0]        mode;
   logic              reloc;
   logic              frozen;
   logic              kt_hit;
   logic              pdr_sel;
   logic              wr_kt;
   logic [2:0]        abort_nxt;
   logic [15:0]       rdata;
   logic [2:0]        key;
   logic [6:0]        permitted_block_count;
   target_t           tgt;

   // Reset release through two flops
   always_ff @(posedge mclk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rst_meta_r <= 1'b0;
         rst_n_r    <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n_r    <= rst_meta_r;
      end
   end

   // Mode select from table bits A B
   always_comb begin
      unique case (ctl_r[3:2])
         2'b00: mode = psx_r[3:2];
         2'b01: mode = tmp_r;
         2'b10: mode = mtp_r ? psx_r[1:0] : psx_r[3:2];
         2'b11: mode = mfp_r ? psx_r[1:0] : psx_r[3:2];
      endcase
   end

   // Relocation enable: normal, or maintenance on destination cycle
   assign reloc = sr0_r[SR0_EN] | (sr0_r[SR0_MAINT] & ctl_r[0]);
   assign pg = req_in.va[15:13];
   assign frozen = |sr0_r[SR0_NRES:SR0_RO];
   assign key = pdr_r[pg][2:0];
   assign permitted_block_count = pdr_r[pg][14:8];

   // Physical address formation
   always_comb begin
      if (console_in)
         pba_nxt = {switch_in[17:6], req_in.va[5:0]};
      else if (reloc)
         pba_nxt = {par_r[pg] + {5'h00, req_in.va[12:6]}, req_in.va[5:0]};
      else
         pba_nxt = {2'b00, req_in.va};
   end

   // Full-address target decode; bit 6 splits base from descriptor
   assign kt_hit = (pba_nxt[17:7] == KT_PAGE_BLK) || (pba_nxt == SR0_ADR)
                   || (pba_nxt == SR2_ADR) || (pba_nxt == PSX_ADR);
   assign pdr_sel = pba_nxt[6];
   always_comb begin
      if (kt_hit)
         tgt = TGT_KT;
      else if (pba_nxt[17:6] == PROC_PAGE)
         tgt = TGT_PROC;
      else
         tgt = TGT_EXT;
   end
   assign wr_kt = req_in.start & req_in.write & kt_hit;

   // Access checks; downward pages use bit 3 of the descriptor
   always_comb begin
      abort_nxt = 3'b000;
      if (req_in.start && reloc && !console_in) begin
         abort_nxt[2] = (key == KEY_NRES0) || (key == KEY_NRES4)
                        || (mode != MODE_KERNEL && mode != MODE_USER);
         if (pdr_r[pg][3])
            abort_nxt[1] = req_in.va[12:6] < permitted_block_count;
         else
            abort_nxt[1] = req_in.va[12:6] > permitted_block_count;
         abort_nxt[0] = req_in.write && (key == KEY_RO);
      end
   end

   // Register read multiplexer
   always_comb begin
      rdata = 16'h0000;
      if (pba_nxt[17:7] == KT_PAGE_BLK)
         rdata = pdr_sel ? pdr_r[req_in.va[3:1]] : {4'h0, par_r[req_in.va[3:1]]};
      else if (pba_nxt == SR0_ADR)
         rdata = sr0_r;
      else if (pba_nxt == SR2_ADR)
         rdata = sr2_r;
      else if (pba_nxt == PSX_ADR)
         rdata = {psx_r, 12'h000};
   end

   // Page base and descriptor storage, one pair per page
   generate
      for (genvar i = 0; i < 8; i++) begin : g_page
         always_ff @(posedge mclk_in or negedge rst_n_r) begin
            if (!rst_n_r) begin
               par_r[i] <= 12'h000;
               pdr_r[i] <= 16'h0000;
            end else if (wr_kt && pba_nxt[17:7] == KT_PAGE_BLK
                         && req_in.va[3:1] == 3'(i)) begin
               if (pdr_sel)
                  pdr_r[i] <= internal_write_data_mux_in & PDR_MASK;
               else
                  par_r[i] <= internal_write_data_mux_in[11:0];
            end
         end
      end
   endgenerate

   // Status/control: new aborts win over a software clear;
   // a write touches only the writable bits so bits 6:1 stay frozen
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         sr0_r <= 16'h0000;
      end else begin
         if (wr_kt && pba_nxt == SR0_ADR)
            sr0_r[15:0] <= (internal_write_data_mux_in & SR0_SW_MASK) | (sr0_r & ~SR0_SW_MASK)
                           | {abort_nxt, 13'h0000};
         else
            sr0_r[15:13] <= sr0_r[15:13] | abort_nxt;
         if (req_in.start && reloc && !frozen) begin
            sr0_r[6:5] <= mode;
            sr0_r[3:1] <= pg;
         end
      end
   end

   // Fetch address capture, held while aborts stand
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r)
         sr2_r <= 16'h0000;
      else if (req_in.start && req_in.fetch && !frozen && abort_nxt == 3'b000)
         sr2_r <= req_in.va;
   end

   // Mode control table output register
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r)
         ctl_r <= 4'h0;
      else
         ctl_r <= ctl_rom(microbranch_pointer_in[7:0]);
   end

   // Mode bits: implicit load beats bus write; C without B shifts current to previous
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         psx_r <= 4'h0;
         tmp_r <= 2'b00;
      end else begin
         if (impl_in.ps_load)
            psx_r <= internal_write_data_mux_in[15:12];
         else if (wr_kt && pba_nxt == PSX_ADR)
            psx_r <= internal_write_data_mux_in[15:12];
         else if (ctl_r[1] && !ctl_r[2])
            psx_r[1:0] <= psx_r[3:2];
         if (ctl_r[1])
            tmp_r <= ctl_r[2] ? psx_r[3:2] : 2'b00;
      end
   end

   // Instruction rewrite; the kind is kept for mode selection
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         mtp_r            <= 1'b0;
         mfp_r            <= 1'b0;
         fetch_repeat_out <= 1'b0;
      end else begin
         fetch_repeat_out <= 1'b0;
         if (impl_in.ir_valid) begin
            mtp_r <= ir_in[14:6] == OP_MTP;
            mfp_r <= ir_in[14:6] == OP_MFP;
            fetch_repeat_out <= (ir_in[14:6] == OP_MTP) || (ir_in[14:6] == OP_MFP)
                                || (ir_in == OP_RESET && psx_r[3:2] == MODE_USER);
         end
      end
   end

   // Register data bus: jammed code beats implicit mode read
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rd_bus_out    <= 16'h0000;
         rd_bus_oe_out <= 1'b0;
      end else begin
         rd_bus_oe_out <= 1'b0;
         rd_bus_out    <= 16'h0000;
         if (impl_in.ir_valid && ir_in == OP_RESET && psx_r[3:2] == MODE_USER) begin
            rd_bus_out    <= OP_NOP;
            rd_bus_oe_out <= 1'b1;
         end else if (impl_in.ir_valid && ir_in[14:6] == OP_MTP) begin
            rd_bus_out    <= MOV_FROM_SP | {10'h000, ir_in[5:0]};
            rd_bus_oe_out <= 1'b1;
         end else if (impl_in.ir_valid && ir_in[14:6] == OP_MFP) begin
            rd_bus_out    <= MOV_TO_SP | {4'h0, ir_in[5:0], 6'h00};
            rd_bus_oe_out <= 1'b1;
         end else if (impl_in.ps_read) begin
            rd_bus_out    <= {psx_r, 12'h000};
            rd_bus_oe_out <= 1'b1;
         end
      end
   end

   // Address, target, bus data and false bus cycle
   always_ff @(posedge mclk_in or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pba_out          <= 18'h00000;
         target_out       <= TGT_EXT;
         bus_data_out     <= 16'h0000;
         bus_data_oe_out  <= 1'b0;
         msyn_inhibit_out <= 1'b0;
         ssyn_out         <= 1'b0;
         fault_out        <= 1'b0;
      end else begin
         pba_out          <= pba_nxt;
         target_out       <= tgt;
         msyn_inhibit_out <= req_in.start & kt_hit;
         ssyn_out         <= req_in.start & kt_hit;
         bus_data_oe_out  <= req_in.start & kt_hit & ~req_in.write;
         bus_data_out     <= (req_in.start & kt_hit & ~req_in.write) ? rdata : 16'h0000;
         fault_out        <= |abort_nxt;
      end
   end

   // Checks
   AST_PASS: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (!console_in && !reloc) |=> pba_out[17:16] == 2'b00)
      else $error("pass-through high bits not zero");
   AST_CONSOLE: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      console_in |=> pba_out == {$past(switch_in[17:6]), $past(req_in.va[5:0])})
      else $error("console address not passed");
   AST_LOWBITS: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      1'b1 |=> pba_out[5:0] == $past(req_in.va[5:0]))
      else $error("low address bits altered");
   AST_FALSE_CYCLE: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (req_in.start && kt_hit) |=> ssyn_out && msyn_inhibit_out && target_out == TGT_KT)
      else $error("own access reached the bus");
   AST_FAULT: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (abort_nxt != 3'b000) |=> fault_out && (sr0_r[15:13] & $past(abort_nxt)) == $past(abort_nxt))
      else $error("abort not flagged");
   AST_RO: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (req_in.start && reloc && !console_in && req_in.write && key == KEY_RO) |=> sr0_r[SR0_RO])
      else $error("read-only write not flagged");
   AST_FREEZE: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      frozen |=> $stable(sr2_r) && $stable(sr0_r[6:1]))
      else $error("status moved while frozen");
   AST_NOP: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (impl_in.ir_valid && ir_in == OP_RESET && psx_r[3:2] == MODE_USER)
      |=> fetch_repeat_out && rd_bus_oe_out && rd_bus_out == OP_NOP)
      else $error("user reset not turned into no-op");
   AST_TABLE: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      1'b1 |=> ctl_r == ctl_rom($past(microbranch_pointer_in[7:0])))
      else $error("table register stale");
   AST_FETCH: assert property (@(posedge mclk_in) disable iff (!rst_n_r)
      (req_in.start && req_in.fetch && !frozen && abort_nxt == 3'b000)
      |=> sr2_r == $past(req_in.va))
      else $error("fetch address not captured");

endmodule

`default_nettype wire

// [hw/vaddr_reloc_pkg.sv]
// Constants, types and control table of the address relocation unit.
// Shared by the unit and by anything that drives or watches its ports.
package vaddr_reloc_pkg;
   localparam int CLK_MHZ = 100;
   // Register map (physical addresses)
   localparam logic [10:0] KT_PAGE_BLK = 11'h7F5; // PAR/PAGE_DESCRIPTOR_REGISTER block, bit 6 splits
   localparam logic [17:0] SR0_ADR = 18'h3FF7A;
   localparam logic [17:0] SR2_ADR = 18'h3FF7E;
   localparam logic [17:0] PSX_ADR = 18'h3FFFE;
   localparam logic [11:0] PROC_PAGE = 12'hFFF; // Processor-internal page
   // Status/control fields
   localparam int SR0_EN = 0;
   localparam int SR0_MAINT = 8;
   localparam int SR0_NRES = 15;
   localparam int SR0_LEN = 14;
   localparam int SR0_RO = 13;
   localparam logic [15:0] SR0_SW_MASK = 16'hE101;
   localparam logic [15:0] PDR_MASK = 16'h7F0F;
   // Descriptor keys and modes
   localparam logic [2:0] KEY_NRES0 = 3'h0;
   localparam logic [2:0] KEY_RO = 3'h2;
   localparam logic [2:0] KEY_NRES4 = 3'h4;
   localparam logic [1:0] MODE_KERNEL = 2'h0;
   localparam logic [1:0] MODE_USER = 2'h3;
   // Instruction patterns
   localparam logic [8:0] OP_MTP = 9'h036;
   localparam logic [8:0] OP_MFP = 9'h035;
   localparam logic [15:0] OP_RESET = 16'h0005;
   localparam logic [15:0] OP_NOP = 16'h00A0;
   localparam logic [15:0] MOV_FROM_SP = 16'h1580; // MOV (SP)+,dd
   localparam logic [15:0] MOV_TO_SP = 16'h1026; // MOV ss,-(SP)
   // Target of an access
   typedef enum logic [1:0] {TGT_EXT, TGT_KT, TGT_PROC} target_t;
   typedef struct packed {
      logic start; logic write; logic fetch; logic [15:0] va;
   } bus_req_t;
   typedef struct packed {
      logic ps_load; logic ps_read; logic ir_valid;
   } impl_t;
   // Mode control table, 4 bits: A B C D
   function automatic logic [3:0] ctl_rom(input logic [7:0] a);
      unique case (a)
         8'h62, 8'h64, 8'h61, 8'hA2, 8'hA6: ctl_rom = 4'hC;
         8'h71, 8'h72, 8'h74, 8'hB2, 8'hB5: ctl_rom = 4'h1;
         8'h85, 8'h81, 8'h94, 8'h95, 8'hF5: ctl_rom = 4'h1;
         8'hF6, 8'h9C, 8'h91, 8'h9E, 8'h90: ctl_rom = 4'h1;
         8'hFC, 8'hBD, 8'hBE: ctl_rom = 4'h1;
         8'h80: ctl_rom = 4'h9;
         8'h84: ctl_rom = 4'h8;
         8'h8D, 8'h07, 8'hD6, 8'hD7, 8'h4B: ctl_rom = 4'h4;
         8'hD8, 8'hD9, 8'hDA: ctl_rom = 4'h4;
         8'h4D, 8'h3F: ctl_rom = 4'h6;
         8'h60: ctl_rom = 4'h2;
         default: ctl_rom = 4'h0;
      endcase
   endfunction
endpackage

// [sim/proc_model.sv]
// Processor-side model: drives requests, implicit transfers and table pointer.
// Assumes one clock; all drives after the time-zero idle values land 1 ns after a rising edge.
`timescale 1ns/1ps
`default_nettype none

module proc_model
   import vaddr_reloc_pkg::*;
(
   input  wire logic        mclk_in,
   output var  bus_req_t    req_out,
   output var  impl_t       impl_out,
   output var  logic [15:0] internal_write_data_mux_out,
   output var  logic [15:0] ir_out,
   output var  logic [8:0]  microbranch_pointer_out,
   output var  logic        console_out,
   output var  logic [17:0] switch_out
);
   // Idle values at time zero
   initial begin
      req_out = '0;
      impl_out = '0;
      internal_write_data_mux_out = 16'h0000;
      ir_out = 16'h0000;
      microbranch_pointer_out = 9'h000;
      console_out = 1'b0;
      switch_out = 18'h00000;
   end

   // One bus access, taken at a single edge
   task automatic acc(input logic cons, input logic wr, input logic fe,
                      input logic [17:0] sw, input logic [15:0] va, input logic [15:0] d);
      @(posedge mclk_in);
      #1;
      console_out = cons;
      switch_out = sw;
      internal_write_data_mux_out = d;
      req_out = '{start: 1'b1, write: wr, fetch: fe, va: va};
      @(posedge mclk_in);
      #1;
      req_out.start = 1'b0;
      // Released lines flip so a stale value never matches by luck
      internal_write_data_mux_out = ~d;
      req_out.va = ~va;
   endtask

   // Implicit transfer or new instruction; ir stays as a register would
   task automatic imp(input impl_t i, input logic [15:0] ir, input logic [15:0] d);
      @(posedge mclk_in);
      #1;
      impl_out = i;
      ir_out = ir;
      internal_write_data_mux_out = d;
      @(posedge mclk_in);
      #1;
      impl_out = '0;
      internal_write_data_mux_out = ~d;
   endtask

   // Microword pointer held one cycle, then let the table settle
   task automatic tbl(input logic [8:0] p);
      @(posedge mclk_in);
      #1;
      microbranch_pointer_out = p;
      @(posedge mclk_in);
      #1;
      microbranch_pointer_out = 9'h000;
      repeat (2) @(posedge mclk_in);
   endtask
endmodule

`default_nettype wire

// [sim/vaddr_reloc_tb_top.sv]
// Self-checking bench for the address relocation unit.
// Assumes the processor model drives every unit input except clock and reset.
`timescale 1ns/1ps
`default_nettype none

module vaddr_reloc_tb_top;
   import vaddr_reloc_pkg::*;
   logic        mclk_in;
   logic        nrst_in;
   bus_req_t    req;
   impl_t       impl;
   logic [15:0] internal_write_data_mux, ir, bus_data_out, rd_bus_out;
   logic [8:0]  microbranch_pointer;
   logic        cons;
   logic [17:0] sw, pba_out;
   logic [1:0]  target_out;
   logic        bus_data_oe_out, rd_bus_oe_out, msyn_inhibit_out, ssyn_out;
   logic        fault_out, fetch_repeat_out;
   int          n_fail = 0;
   int          check_count = 0;

   vaddr_reloc vaddr_reloc_inst (.mclk_in(mclk_in), .nrst_in(nrst_in), .req_in(req),
      .impl_in(impl), .internal_write_data_mux_in(internal_write_data_mux), .ir_in(ir), .microbranch_pointer_in(microbranch_pointer), .console_in(cons),
      .switch_in(sw), .pba_out(pba_out), .target_out(target_out),
      .bus_data_out(bus_data_out), .bus_data_oe_out(bus_data_oe_out),
      .rd_bus_out(rd_bus_out), .rd_bus_oe_out(rd_bus_oe_out),
      .msyn_inhibit_out(msyn_inhibit_out), .ssyn_out(ssyn_out),
      .fault_out(fault_out), .fetch_repeat_out(fetch_repeat_out));
   proc_model proc_model_inst (.mclk_in(mclk_in), .req_out(req), .impl_out(impl),
      .internal_write_data_mux_out(internal_write_data_mux), .ir_out(ir), .microbranch_pointer_out(microbranch_pointer), .console_out(cons),
      .switch_out(sw));

   // 100 MHz clock
   initial mclk_in = 1'b0;
   always #5 mclk_in = ~mclk_in;

   task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Own register access through the console switches; d is write data or read expectation
   task automatic rg(input logic wr, input logic [17:0] a, input logic [15:0] d);
      proc_model_inst.acc(1'b1, wr, 1'b0, a, {10'h000, a[5:0]}, d);
      chk(pba_out, a);
      chk(18'({ssyn_out, msyn_inhibit_out, target_out}), 18'h0000D);
      if (!wr)
         chk(18'({bus_data_oe_out, bus_data_out}), 18'({1'b1, d}));
   endtask

   // Relocated access in page 1; returns with outputs of the taking edge
   task automatic rel(input logic wr, input logic fe, input logic [15:0] va,
                      input logic flt);
      proc_model_inst.acc(1'b0, wr, fe, 18'h00000, va, 16'h5A5A);
      chk(18'(fault_out), 18'(flt));
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Guard against a hang
   initial begin
      #500000;
      n_fail++;
      results();
   end

   // Main sequence
   initial begin
      nrst_in = 1'b0;
      repeat (20) @(posedge mclk_in);
      #1;
      nrst_in = 1'b1;
      repeat (3) @(posedge mclk_in);
      proc_model_inst.acc(1'b0, 1'b0, 1'b0, 18'h00000, 16'hABCD, 16'h0000);
      chk(pba_out, 18'h0ABCD);
      chk(18'({ssyn_out, target_out}), 18'h00000);
      proc_model_inst.acc(1'b1, 1'b0, 1'b0, 18'h3FFC0, 16'h0000, 16'h0000);
      chk(18'(target_out), 18'h00002);
      $display("test pass_through done");
      rg(1'b1, 18'h3FA82, 16'hF123);
      rg(1'b0, 18'h3FA82, 16'h0123);
      rg(1'b1, 18'h3FAC2, 16'hFFFF);
      rg(1'b0, 18'h3FAC2, 16'h7F0F);
      rg(1'b1, 18'h3FAC2, 16'h0A06);
      rg(1'b0, 18'h3FA80, 16'h0000);
      rg(1'b1, SR0_ADR, 16'h0001);
      rg(1'b0, SR0_ADR, 16'h0001);
      $display("test registers done");
      rel(1'b0, 1'b1, 16'h2152, 1'b0);
      chk(pba_out, {12'h123 + 12'h005, 6'h12});
      rg(1'b1, SR2_ADR, 16'hFFFF);
      rg(1'b0, SR2_ADR, 16'h2152);
      rel(1'b0, 1'b0, 16'h22C0, 1'b1);
      rel(1'b0, 1'b1, 16'h2050, 1'b0);
      rg(1'b0, SR2_ADR, 16'h2152);
      rg(1'b0, SR0_ADR, 16'h4003);
      rg(1'b1, SR0_ADR, 16'h0001);
      $display("test length_abort done");
      rg(1'b1, 18'h3FAC2, 16'h0A02);
      rel(1'b0, 1'b0, 16'h2046, 1'b0);
      rel(1'b1, 1'b0, 16'h2046, 1'b1);
      rg(1'b0, SR0_ADR, 16'h2003);
      rg(1'b1, SR0_ADR, 16'h0001);
      $display("test read_only done");
      proc_model_inst.imp(3'h1, OP_RESET, 16'h0000);
      chk(18'({fetch_repeat_out, rd_bus_oe_out}), 18'h00000);
      proc_model_inst.imp(3'h1, {1'b0, OP_MTP, 6'h05}, 16'h0000);
      chk(18'({fetch_repeat_out, rd_bus_oe_out, rd_bus_out}), 18'h31585);
      proc_model_inst.imp(3'h1, {1'b0, OP_MFP, 6'h05}, 16'h0000);
      chk(18'({fetch_repeat_out, rd_bus_oe_out, rd_bus_out}), 18'h31166);
      $display("test move_rewrite done");
      proc_model_inst.imp(3'h4, 16'h0000, 16'hF000);
      proc_model_inst.imp(3'h2, 16'h0000, 16'h0000);
      chk(18'({rd_bus_oe_out, rd_bus_out}), 18'h1F000);
      rg(1'b0, PSX_ADR, 16'hF000);
      proc_model_inst.imp(3'h1, OP_RESET, 16'h0000);
      chk(18'({fetch_repeat_out, rd_bus_oe_out, rd_bus_out}), 18'h300A0);
      $display("test user_reset done");
      proc_model_inst.imp(3'h4, 16'h0000, 16'hC000);
      proc_model_inst.tbl(9'h060);
      proc_model_inst.imp(3'h2, 16'h0000, 16'h0000);
      chk(18'({rd_bus_oe_out, rd_bus_out}), 18'h1F000);
      $display("test mode_table done");
      results();
   end
endmodule

`default_nettype wire
